// File: verilog/lpc_regs.sv
// How it works
// R01 - unused bits of both registers ignore writes and read zero
// R02 - blink field picks 50, 100, 200 or 500 ms phases, resets to 10
// R03 - per-LED polarity bit, strap-loaded, 1 active high, 0 active low
// R04 - force bit set drives the matching value bit onto that LED
// R05 - auto crossover enable bit, strap-loaded, default one
// R06 - forced crossover bit swaps transmit and receive pairs
// R07 - receive pause status from pause resolution, only full duplex
// R08 - transmit pause status from pause resolution, only full duplex
// R09 - link status reads one only for autonegotiated 100 full duplex
// R10 - bypass bit makes LEDs follow raw status without stretching
// R11 - mode one: link LED shows link, activity LED pulses on activity
// R12 - mode two link/speed/collision; mode three blink link, duplex
// R13 - read-only port address field captured from straps at reset
// R14 - blink phases counted from the reference clock
`timescale 1ns/10ps
`include "lpc_defines.svh"
module lpc_regs
	import lpc_pkg::*;
#(
	parameter int unsigned BLINK0_CYC = `LPC_BLINK0_CYC,
	parameter int unsigned BLINK1_CYC = `LPC_BLINK1_CYC,
	parameter int unsigned BLINK2_CYC = `LPC_BLINK2_CYC,
	parameter int unsigned BLINK3_CYC = `LPC_BLINK3_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic strap_speed_pol,
	input wire logic strap_link_pol,
	input wire logic strap_act_pol,
	input wire logic strap_auto_crossover,
	input wire logic strap_indicator_mode,
	input wire logic [4:0] strap_port_addr,
	input wire logic link_good,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic activity,
	input wire logic collision,
	input wire logic an_complete,
	input wire logic hcd_full_duplex,
	input wire logic [1:0] local_pause_adv,
	input wire logic [1:0] partner_pause_adv,
	output logic speed_indicator_out,
	output logic link_indicator_out,
	output logic activity_indicator_out,
	output logic auto_crossover_en,
	output logic pair_crossover,
	output logic pause_rx_en,
	output logic pause_tx_en,
	output logic fd100_link
);
	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [9:0] strap_sync;
	lpc_strap_e strap_st_ff;
	lpc_strap_e nxt_strap_st;
	logic [1:0] blink_ff;
	logic pol_speed_ff, pol_link_ff, pol_act_ff;
	logic [2:0] drv_ff;
	logic [2:0] val_ff;
	logic auto_x_ff, force_x_ff, bypass_ff;
	logic [1:0] mode_ff;
	logic [4:0] port_addr_ff;
	logic pause_rx_ff, pause_tx_ff, fd100_ff;
	logic pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;
	logic act_hold_ff, col_hold_ff;
	logic speed_out_ff, link_out_ff, act_out_ff;
	logic blink_phase, blink_tick;
	logic hit_led, hit_phy, wr_led, wr_phy;
	logic [15:0] led_rd, phy_rd;
	logic nxt_rx, nxt_tx;
	lpc_mode_e mode;
	logic act_src, col_src;
	logic on_speed, on_link, on_act;
	logic drv_speed, drv_link, drv_act;

	////////////////////////////////////////////////////////////////////////
	// strap pins and blink timer
	lpc_sync #(
		.W(10)
	) u_strap_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({strap_speed_pol, strap_link_pol, strap_act_pol,
			strap_auto_crossover, strap_indicator_mode, strap_port_addr}),
		.q(strap_sync)
	);

	lpc_blink #(
		.T0_CYC(BLINK0_CYC),
		.T1_CYC(BLINK1_CYC),
		.T2_CYC(BLINK2_CYC),
		.T3_CYC(BLINK3_CYC)
	) u_blink (
		.pclk(pclk),
		.presetn(presetn),
		.rate(blink_ff), // R02
		.phase(blink_phase),
		.tick(blink_tick)
	);

	// wait for synchroniser to fill, load straps once, then run
	always_comb begin
		case (strap_st_ff)
			LPC_ST_SETTLE1: nxt_strap_st = LPC_ST_SETTLE2;
			LPC_ST_SETTLE2: nxt_strap_st = LPC_ST_LOAD;
			LPC_ST_LOAD: nxt_strap_st = LPC_ST_RUN;
			LPC_ST_RUN: nxt_strap_st = LPC_ST_RUN;
			default: nxt_strap_st = LPC_ST_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_st_ff <= LPC_ST_SETTLE1;
		end else begin
			strap_st_ff <= nxt_strap_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb decode: no wait states, ready registered from the setup cycle
	assign hit_led = (paddr == `LPC_ADDR_LED_OVR);
	assign hit_phy = (paddr == `LPC_ADDR_PHY_GEN);
	assign wr_led = psel & penable & pready_ff & pwrite & hit_led;
	assign wr_phy = psel & penable & pready_ff & pwrite & hit_phy;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'h0;
			pslverr_ff <= 1'h0;
		end else begin
			pready_ff <= psel & ~penable;
			pslverr_ff <= psel & ~penable & ~(hit_led | hit_phy);
		end
	end

	// read data captured in every setup; writes and misses give zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0;
		end else if (psel & ~penable) begin
			if (~pwrite & hit_led) begin
				prdata_ff <= {16'h0, led_rd}; // R01
			end else if (~pwrite & hit_phy) begin
				prdata_ff <= {16'h0, phy_rd}; // R01
			end else begin
				prdata_ff <= 32'h0;
			end
		end
	end

	// reserved bits tied to zero in the read images
	always_comb begin
		led_rd = 16'h0; // R01
		led_rd[`LPC_LED_BLINK_MSB:`LPC_LED_BLINK_LSB] = blink_ff;
		led_rd[`LPC_LED_POL_SPEED] = pol_speed_ff;
		led_rd[`LPC_LED_POL_LINK] = pol_link_ff;
		led_rd[`LPC_LED_POL_ACT] = pol_act_ff;
		led_rd[`LPC_LED_DRV_SPEED:`LPC_LED_DRV_ACT] = drv_ff;
		led_rd[`LPC_LED_VAL_SPEED:`LPC_LED_VAL_ACT] = val_ff;
		phy_rd = 16'h0; // R01
		phy_rd[`LPC_PHY_AUTO_X] = auto_x_ff;
		phy_rd[`LPC_PHY_FORCE_X] = force_x_ff;
		phy_rd[`LPC_PHY_PAUSE_RX] = pause_rx_ff;
		phy_rd[`LPC_PHY_PAUSE_TX] = pause_tx_ff;
		phy_rd[`LPC_PHY_LINK_FD100] = fd100_ff;
		phy_rd[`LPC_PHY_BYPASS] = bypass_ff;
		phy_rd[`LPC_PHY_MODE_MSB:`LPC_PHY_MODE_LSB] = mode_ff;
		phy_rd[`LPC_PORT_ADDRESS_FIELD_MSB:`LPC_PORT_ADDRESS_FIELD_LSB] = port_addr_ff;
	end

	////////////////////////////////////////////////////////////////////////
	// led_override_control storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_ff <= `LPC_RST_BLINK; // R02
			pol_speed_ff <= `LPC_RST_POL;
			pol_link_ff <= `LPC_RST_POL;
			pol_act_ff <= `LPC_RST_POL;
			drv_ff <= {3{`LPC_RST_DRV}};
			val_ff <= {3{`LPC_RST_VAL}};
		end else if (strap_st_ff == LPC_ST_LOAD) begin
			pol_speed_ff <= strap_sync[9]; // R03
			pol_link_ff <= strap_sync[8]; // R03
			pol_act_ff <= strap_sync[7]; // R03
		end else if (wr_led) begin
			blink_ff <= pwdata[`LPC_LED_BLINK_MSB:`LPC_LED_BLINK_LSB]; // R02
			pol_speed_ff <= pwdata[`LPC_LED_POL_SPEED]; // R03
			pol_link_ff <= pwdata[`LPC_LED_POL_LINK]; // R03
			pol_act_ff <= pwdata[`LPC_LED_POL_ACT]; // R03
			drv_ff <= pwdata[`LPC_LED_DRV_SPEED:`LPC_LED_DRV_ACT]; // R04
			val_ff <= pwdata[`LPC_LED_VAL_SPEED:`LPC_LED_VAL_ACT]; // R04
		end
	end

	////////////////////////////////////////////////////////////////////////
	// phy_general_control writable and strapped fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_x_ff <= `LPC_RST_AUTO_X; // R05
			force_x_ff <= `LPC_RST_FORCE_X;
			bypass_ff <= `LPC_RST_BYPASS;
			mode_ff <= `LPC_RST_MODE;
			port_addr_ff <= `LPC_RST_ADDR;
		end else if (strap_st_ff == LPC_ST_LOAD) begin
			auto_x_ff <= strap_sync[6]; // R05
			mode_ff <= {1'h0, strap_sync[5]};
			port_addr_ff <= strap_sync[4:0]; // R13
		end else if (wr_phy) begin
			auto_x_ff <= pwdata[`LPC_PHY_AUTO_X]; // R05
			force_x_ff <= pwdata[`LPC_PHY_FORCE_X]; // R06
			bypass_ff <= pwdata[`LPC_PHY_BYPASS]; // R10
			mode_ff <= pwdata[`LPC_PHY_MODE_MSB:`LPC_PHY_MODE_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pause resolution; bit 1 asymmetric, bit 0 symmetric pause
	always_comb begin
		nxt_rx = 1'h0;
		nxt_tx = 1'h0;
		if (local_pause_adv[0] & partner_pause_adv[0]) begin
			nxt_rx = 1'h1;
			nxt_tx = 1'h1;
		end else if (local_pause_adv == 2'h2 && partner_pause_adv == 2'h3) begin
			nxt_tx = 1'h1;
		end else if (local_pause_adv == 2'h3 && partner_pause_adv == 2'h2) begin
			nxt_rx = 1'h1;
		end
	end

	// read-only status, pause gated by full duplex common mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pause_rx_ff <= 1'h0;
			pause_tx_ff <= 1'h0;
			fd100_ff <= 1'h0;
		end else begin
			pause_rx_ff <= nxt_rx & an_complete & hcd_full_duplex; // R07
			pause_tx_ff <= nxt_tx & an_complete & hcd_full_duplex; // R08
			fd100_ff <= link_good & speed_100 & full_duplex & an_complete; // R09
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stretch events until the next blink boundary; new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_hold_ff <= 1'h0;
			col_hold_ff <= 1'h0;
		end else begin
			act_hold_ff <= activity | (act_hold_ff & ~blink_tick);
			col_hold_ff <= collision | (col_hold_ff & ~blink_tick);
		end
	end

	assign act_src = bypass_ff ? activity : (activity | act_hold_ff); // R10
	assign col_src = bypass_ff ? collision : (collision | col_hold_ff); // R10

	////////////////////////////////////////////////////////////////////////
	// indicator mode decode and status selection
	always_comb begin
		if (mode_ff[0]) begin
			mode = LPC_MODE_ONE; // R11
		end else if (mode_ff[1]) begin
			mode = LPC_MODE_THREE; // R12
		end else begin
			mode = LPC_MODE_TWO; // R12
		end
	end

	always_comb begin
		on_speed = speed_100;
		case (mode)
			LPC_MODE_ONE: begin
				on_link = link_good; // R11
				on_act = act_src; // R11
			end
			LPC_MODE_TWO: begin
				on_link = link_good; // R12
				on_speed = speed_100; // R12
				on_act = col_src; // R12
			end
			LPC_MODE_THREE: begin
				on_link = link_good & ~(act_src & blink_phase); // R12
				on_act = full_duplex; // R12
			end
			default: begin
				on_link = link_good;
				on_act = act_src;
			end
		endcase
	end

	// override by force bits, then apply polarity
	assign drv_speed = drv_ff[2] ? val_ff[2] : on_speed; // R04
	assign drv_link = drv_ff[1] ? val_ff[1] : on_link; // R04
	assign drv_act = drv_ff[0] ? val_ff[0] : on_act; // R04

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_out_ff <= 1'h0;
			link_out_ff <= 1'h0;
			act_out_ff <= 1'h0;
		end else begin
			speed_out_ff <= drv_speed ^ ~pol_speed_ff; // R03
			link_out_ff <= drv_link ^ ~pol_link_ff; // R03
			act_out_ff <= drv_act ^ ~pol_act_ff; // R03
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign speed_indicator_out = speed_out_ff;
	assign link_indicator_out = link_out_ff;
	assign activity_indicator_out = act_out_ff;
	assign auto_crossover_en = auto_x_ff; // R05
	assign pair_crossover = force_x_ff; // R06
	assign pause_rx_en = pause_rx_ff;
	assign pause_tx_en = pause_tx_ff;
	assign fd100_link = fd100_ff;
endmodule // lpc_regs

// File: verilog/lpc_defines.svh
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH

// register indices and byte addresses (byte address = 4 * index)
`define LPC_IDX_LED_OVR 6'h18
`define LPC_IDX_PHY_GEN 6'h19
`define LPC_ADDR_LED_OVR ({`LPC_IDX_LED_OVR, 2'h0})
`define LPC_ADDR_PHY_GEN ({`LPC_IDX_PHY_GEN, 2'h0})

// led_override_control field positions
`define LPC_LED_BLINK_MSB 10
`define LPC_LED_BLINK_LSB 9
`define LPC_LED_POL_SPEED 8
`define LPC_LED_POL_LINK 7
`define LPC_LED_POL_ACT 6
`define LPC_LED_DRV_SPEED 5
`define LPC_LED_DRV_LINK 4
`define LPC_LED_DRV_ACT 3
`define LPC_LED_VAL_SPEED 2
`define LPC_LED_VAL_LINK 1
`define LPC_LED_VAL_ACT 0

// phy_general_control field positions
`define LPC_PHY_AUTO_X 15
`define LPC_PHY_FORCE_X 14
`define LPC_PHY_PAUSE_RX 13
`define LPC_PHY_PAUSE_TX 12
`define LPC_PHY_LINK_FD100 11
`define LPC_PHY_BYPASS 7
`define LPC_PHY_MODE_MSB 6
`define LPC_PHY_MODE_LSB 5
`define LPC_PORT_ADDRESS_FIELD_MSB 4
`define LPC_PORT_ADDRESS_FIELD_LSB 0

// reset values (strapped bits are reloaded from pins after release)
`define LPC_RST_BLINK 2'h2
`define LPC_RST_POL 1'h0
`define LPC_RST_DRV 1'h0
`define LPC_RST_VAL 1'h0
`define LPC_RST_AUTO_X 1'h1
`define LPC_RST_FORCE_X 1'h0
`define LPC_RST_BYPASS 1'h0
`define LPC_RST_MODE 2'h0
`define LPC_RST_ADDR 5'h00

// timing
`define LPC_CLK_KHZ 125000
`define LPC_BLINK0_MS 50
`define LPC_BLINK1_MS 100
`define LPC_BLINK2_MS 200
`define LPC_BLINK3_MS 500
`define LPC_BLINK0_CYC (`LPC_BLINK0_MS * `LPC_CLK_KHZ)
`define LPC_BLINK1_CYC (`LPC_BLINK1_MS * `LPC_CLK_KHZ)
`define LPC_BLINK2_CYC (`LPC_BLINK2_MS * `LPC_CLK_KHZ)
`define LPC_BLINK3_CYC (`LPC_BLINK3_MS * `LPC_CLK_KHZ)

`endif

// File: verilog/lpc_pkg.sv
package lpc_pkg;
	// strap capture sequence after reset release
	typedef enum logic [1:0] {
		LPC_ST_SETTLE1,
		LPC_ST_SETTLE2,
		LPC_ST_LOAD,
		LPC_ST_RUN
	} lpc_strap_e;
	// indicator mode decoded from the mode field
	typedef enum logic [1:0] {
		LPC_MODE_ONE,
		LPC_MODE_TWO,
		LPC_MODE_THREE
	} lpc_mode_e;
endpackage

// File: verilog/lpc_sync.sv
`timescale 1ns/10ps
module lpc_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// two flops, the first read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule // lpc_sync

// File: verilog/lpc_blink.sv
`timescale 1ns/10ps
module lpc_blink #(
	parameter int unsigned T0_CYC = 1,
	parameter int unsigned T1_CYC = 1,
	parameter int unsigned T2_CYC = 1,
	parameter int unsigned T3_CYC = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] rate,
	output logic phase,
	output logic tick
);
	logic [31:0] cnt_ff;
	logic [31:0] lim;
	logic phase_ff;
	logic tick_ff;

	// phase length in cycles for the chosen rate
	always_comb begin
		case (rate)
			2'h0: lim = 32'(T0_CYC);
			2'h1: lim = 32'(T1_CYC);
			2'h2: lim = 32'(T2_CYC);
			default: lim = 32'(T3_CYC);
		endcase
	end

	// count reference clocks, toggle phase at each period end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 32'h0;
			phase_ff <= 1'h0;
			tick_ff <= 1'h0;
		end else if (cnt_ff >= lim - 32'h1) begin // R14
			cnt_ff <= 32'h0;
			phase_ff <= ~phase_ff;
			tick_ff <= 1'h1;
		end else begin
			cnt_ff <= cnt_ff + 32'h1;
			tick_ff <= 1'h0;
		end
	end

	assign phase = phase_ff;
	assign tick = tick_ff;
endmodule // lpc_blink

// File: tb/lpc_regs_props.sv
`timescale 1ns/10ps
`include "lpc_defines.svh"
module lpc_regs_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic link_good,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic an_complete,
	input wire logic hcd_full_duplex,
	input wire logic [1:0] local_pause_adv,
	input wire logic [1:0] partner_pause_adv,
	input wire logic speed_indicator_out,
	input wire logic activity_indicator_out,
	input wire logic auto_crossover_en,
	input wire logic pair_crossover,
	input wire logic pause_rx_en,
	input wire logic pause_tx_en,
	input wire logic fd100_link
);
	logic acc, hit, wled, wphy, sym, rx_x, tx_x, fd_x;
	logic [3:0] adv;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// decoded accesses and expected status levels
	assign acc = psel && penable && pready && pwrite;
	assign hit = paddr == `LPC_ADDR_LED_OVR || paddr == `LPC_ADDR_PHY_GEN;
	assign wled = acc && paddr == `LPC_ADDR_LED_OVR;
	assign wphy = acc && paddr == `LPC_ADDR_PHY_GEN;
	assign adv = {local_pause_adv, partner_pause_adv};
	assign sym = adv[2] && adv[0];
	assign tx_x = an_complete && hcd_full_duplex && (sym || adv == 4'hB);
	assign rx_x = an_complete && hcd_full_duplex && (sym || adv == 4'hE);
	assign fd_x = link_good && speed_100 && full_duplex && an_complete;
	////////////////////////////////////////////////////////////////
	rdy_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	rdy_one_cycle_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	unmapped_err_a: assert property (psel && !penable && !hit
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	led_resv_zero_a: assert property (
		pready && !pwrite && paddr == `LPC_ADDR_LED_OVR
		|-> prdata[31:11] == 21'h0)
		else $error("led reserved bits not zero");
	phy_resv_zero_a: assert property (
		pready && !pwrite && paddr == `LPC_ADDR_PHY_GEN
		|-> prdata[31:16] == 16'h0 && prdata[10:8] == 3'h0)
		else $error("phy reserved bits not zero");
	cross_force_a: assert property (
		wphy |-> ##2 pair_crossover == $past(pwdata[14], 2))
		else $error("forced crossover not applied");
	cross_auto_a: assert property (
		wphy |-> ##2 auto_crossover_en == $past(pwdata[15], 2))
		else $error("auto crossover not applied");
	force_act_a: assert property (wled && pwdata[3] |-> ##2
		activity_indicator_out == ($past(pwdata[0], 2) ~^ $past(pwdata[6], 2)))
		else $error("activity force wrong");
	force_speed_a: assert property (wled && pwdata[5] |-> ##2
		speed_indicator_out == ($past(pwdata[2], 2) ~^ $past(pwdata[8], 2)))
		else $error("speed force wrong");
	pause_tx_a: assert property (
		$past(presetn) |-> pause_tx_en == $past(tx_x))
		else $error("transmit pause wrong");
	pause_rx_a: assert property (presetn |=> pause_rx_en == $past(rx_x))
		else $error("receive pause wrong");
	fd100_a: assert property (presetn |=> fd100_link == $past(fd_x))
		else $error("full duplex link wrong");
	// main scenarios reached
	cover property (wled && pwdata[3]);
	cover property (pslverr);
	cover property (pause_tx_en && pause_rx_en);
endmodule // lpc_regs_props

// File: tb/lpc_led_board.sv
`timescale 1ns/10ps
module lpc_led_board (
	input wire logic [2:0] pin,
	input wire logic [2:0] pol,
	output logic [2:0] lit
);
	// an LED lights when its pin sits at the wired active level
	assign lit = ~(pin ^ pol);
endmodule // lpc_led_board

// File: tb/test_led_and_phy_control_regs.sv
`timescale 1ns/10ps
`include "lpc_defines.svh"
module test_led_and_phy_control_regs import lpc_pkg::*;;
	localparam int T[4] = '{4, 6, 8, 10};
	localparam logic [7:0] AL = `LPC_ADDR_LED_OVR;
	localparam logic [7:0] AP = `LPC_ADDR_PHY_GEN;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, smode = 1'h1, lg = 1'h0, s100 = 1'h0, fd = 1'h0;
	logic act = 1'h0, col = 1'h0, anc = 1'h0, hcd = 1'h0, sax = 1'h1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, rxe, txe;
	logic [2:0] spol = 3'h5, bpol = 3'h0, lit;
	logic [4:0] sadr = 5'h0B, v;
	logic [1:0] lpa = 2'h0, ppa = 2'h0;
	logic led_s, led_l, led_a, axe, pxo, prx, ptx, f100;
	int num_errors = 0, num_checks = 0, cyc = 0, n;
	////////////////////////////////////////////////////////////////
	// design and board
	lpc_regs #(.BLINK0_CYC(T[0]), .BLINK1_CYC(T[1]), .BLINK2_CYC(T[2]),
		.BLINK3_CYC(T[3])) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.strap_speed_pol(spol[2]), .strap_link_pol(spol[1]),
		.strap_act_pol(spol[0]), .strap_auto_crossover(sax),
		.strap_indicator_mode(smode), .strap_port_addr(sadr),
		.link_good(lg), .speed_100(s100), .full_duplex(fd), .activity(act),
		.collision(col), .an_complete(anc), .hcd_full_duplex(hcd),
		.local_pause_adv(lpa), .partner_pause_adv(ppa),
		.speed_indicator_out(led_s), .link_indicator_out(led_l),
		.activity_indicator_out(led_a), .auto_crossover_en(axe),
		.pair_crossover(pxo), .pause_rx_en(prx), .pause_tx_en(ptx),
		.fd100_link(f100));
	lpc_led_board BRD (.pin({led_s, led_l, led_a}), .pol(bpol), .lit(lit));
	////////////////////////////////////////////////////////////////
	// clock and hang limit
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// one bus transfer, entered and left just after an edge
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic rc(string nm, logic [7:0] a, logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(nm, r, exp);
	endtask
	task automatic lc(string nm, logic [2:0] exp);
		repeat (3) @(posedge pclk);
		chk(nm, {29'h0, lit}, {29'h0, exp});
	endtask
	// cycles until the link LED next changes
	task automatic tog();
		logic o;
		o = led_l;
		n = 0;
		while (led_l === o && n < 100) begin
			@(posedge pclk);
			n++;
		end
	endtask
	// one-cycle activity pulse, board read two edges after it ends
	task automatic pulse(string nm, logic [2:0] exp);
		act <= 1'h1;
		@(posedge pclk);
		act <= 1'h0;
		repeat (2) @(posedge pclk);
		chk(nm, {29'h0, lit}, {29'h0, exp});
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		repeat (6) @(posedge pclk);
		rc("led rst", AL, {21'h0, 2'h2, spol, 6'h0});
		rc("phy rst", AP, {16'h0, 1'h1, 8'h0, 1'h0, smode, sadr});
		apb(1'h1, AL, 32'hFFFF_FFFF);
		bpol <= 3'h7;
		rc("led resv", AL, 32'h0000_07FF);
		lc("force on", 3'h7);
		apb(1'h1, AL, 32'h0000_0438);
		bpol <= 3'h0;
		lc("force off", 3'h0);
		chk("pins", {29'h0, led_s, led_l, led_a}, 32'h7);
		apb(1'h1, AL, 32'h0000_043F);
		lc("force low", 3'h7);
		apb(1'h1, AP, 32'hFFFF_FFFF);
		rc("phy wr", AP, {16'h0, 8'hC0, 3'h7, sadr});
		chk("xover", {30'h0, axe, pxo}, 32'h3);
		apb(1'h1, AP, 32'h0);
		rc("phy clr", AP, {27'h0, sadr});
		chk("xover off", {30'h0, axe, pxo}, 32'h0);
		apb(1'h1, 8'h68, 32'hFFFF);
		chk("unmapped", {31'h0, e}, 32'h1);
		rc("unmapped rd", 8'h68, 32'h0);
		anc <= 1'h1;
		for (int i = 0; i < 32; i++) begin
			v = i[4:0];
			{hcd, lpa, ppa} <= v;
			@(posedge pclk);
			txe = v[4] & (v[2] & v[0] | v[3:0] == 4'hB);
			rxe = v[4] & (v[2] & v[0] | v[3:0] == 4'hE);
			rc("pause", AP, {18'h0, rxe, txe, 7'h0, sadr});
			chk("pause pin", {30'h0, prx, ptx}, {30'h0, rxe, txe});
		end
		{lpa, ppa} <= 4'h0;
		{lg, s100, fd, col} <= 4'hF;
		@(posedge pclk);
		rc("fd100", AP, {21'h1, 6'h0, sadr});
		chk("fd100 pin", {31'h0, f100}, 32'h1);
		anc <= 1'h0;
		@(posedge pclk);
		rc("fd100 no an", AP, {27'h0, sadr});
		chk("fd100 pin off", {31'h0, f100}, 32'h0);
		apb(1'h1, AL, 32'h0000_05C0);
		bpol <= 3'h7;
		apb(1'h1, AP, 32'h80);
		lc("mode two", 3'h7);
		apb(1'h1, AP, 32'hE0);
		lc("mode one", 3'h6);
		lg <= 1'h0;
		lc("mode one down", 3'h4);
		lg <= 1'h1;
		apb(1'h1, AP, 32'hC0);
		lc("mode three", 3'h7);
		fd <= 1'h0;
		lc("mode three half", 3'h6);
		act <= 1'h1;
		for (int k = 0; k < 4; k++) begin
			apb(1'h1, AL, {21'h0, k[1:0], 9'h1C0});
			tog();
			tog();
			tog();
			chk("blink", n, T[k]);
		end
		// raw versus stretched activity in mode one
		act <= 1'h0;
		apb(1'h1, AP, 32'hA0);
		pulse("raw pulse", 3'h6);
		apb(1'h1, AP, 32'h20);
		repeat (10) @(posedge pclk);
		lc("stretch idle", 3'h6);
		pulse("stretch pulse", 3'h7);
		// second reset with other strap levels
		spol <= 3'h2;
		sax <= 1'h0;
		smode <= 1'h0;
		sadr <= 5'h14;
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		repeat (6) @(posedge pclk);
		rc("led rst2", AL, {21'h0, 2'h2, 3'h2, 6'h0});
		rc("phy rst2", AP, {27'h0, 5'h14});
		test_done();
	end
endmodule // test_led_and_phy_control_regs

bind lpc_regs lpc_regs_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.link_good(link_good), .speed_100(speed_100),
	.full_duplex(full_duplex), .an_complete(an_complete),
	.hcd_full_duplex(hcd_full_duplex), .local_pause_adv(local_pause_adv),
	.partner_pause_adv(partner_pause_adv),
	.speed_indicator_out(speed_indicator_out),
	.activity_indicator_out(activity_indicator_out),
	.auto_crossover_en(auto_crossover_en), .pair_crossover(pair_crossover),
	.pause_rx_en(pause_rx_en), .pause_tx_en(pause_tx_en),
	.fd100_link(fd100_link));
